//--- verif/gpodc_pin_model.sv
// model: codec and flash pads as seen from the far side
`timescale 1ns/10ps
module gpodc_pin_model (
   input  wire logic       i_ref_clk,
   input  wire logic [9:0] i_lvl,
   input  wire logic [9:0] i_oe_n,
   output logic      [9:0] o_pin
);
   logic [9:0] last_ff;

   always_ff @(posedge i_ref_clk)
   begin
      last_ff <= i_lvl;
   end

   // a released pad shows the inverse of the last offered level, so a stale level never
   // passes for a drive
   assign o_pin = (i_lvl & ~i_oe_n) | (~last_ff & i_oe_n);
endmodule : gpodc_pin_model

//--- verif/gpodc_top_monitor.sv
// checker: pin mux and register readback relations of the codec/flash output block
`timescale 1ns/10ps
module gpodc_top_monitor (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_srst,
   input  wire gpodc_pkg::gpodc_bus_req_s i_bus,
   input  wire logic [31:0]               o_rdata,
   input  wire gpodc_pkg::gpodc_codec_s   i_codec_gpo_en,
   input  wire gpodc_pkg::gpodc_flash_s   i_flash_gpo_en,
   input  wire gpodc_pkg::gpodc_codec_s   i_codec_func_lvl,
   input  wire gpodc_pkg::gpodc_codec_s   i_codec_func_oe_n,
   input  wire gpodc_pkg::gpodc_flash_s   i_flash_func_lvl,
   input  wire gpodc_pkg::gpodc_flash_s   i_flash_func_oe_n,
   input  wire gpodc_pkg::gpodc_codec_s   o_codec_lvl,
   input  wire gpodc_pkg::gpodc_codec_s   o_codec_oe_n,
   input  wire gpodc_pkg::gpodc_flash_s   o_flash_lvl,
   input  wire gpodc_pkg::gpodc_flash_s   o_flash_oe_n
);
   // ***************************************************************
   // shadow copies of the two data registers
   // ***************************************************************
   logic [4:0] sh_c_ff;
   logic [4:0] sh_f_ff;
   logic       map_ok;

   assign map_ok = i_bus.addr inside {gpodc_pkg::CODEC_DATA_OFS, gpodc_pkg::FLASH_DATA_OFS,
                                      gpodc_pkg::CODEC_LEVEL_OFS, gpodc_pkg::FLASH_LEVEL_OFS};

   always_ff @(posedge i_ref_clk)
   begin
      sh_c_ff <= i_srst ? 5'h00 : (i_bus.wr && i_bus.addr == gpodc_pkg::CODEC_DATA_OFS) ?
                 i_bus.wdata[4:0] : sh_c_ff;
      sh_f_ff <= i_srst ? 5'h00 : (i_bus.wr && i_bus.addr == gpodc_pkg::FLASH_DATA_OFS) ?
                 i_bus.wdata[4:0] : sh_f_ff;
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   a_codec_lvl_mux: assert property (!i_srst |=>
      o_codec_lvl == (($past(i_codec_gpo_en) & $past(sh_c_ff)) |
      (~$past(i_codec_gpo_en) & $past(i_codec_func_lvl))))
      else $error("codec pin level mismatch");
   a_codec_oe_mux: assert property (!i_srst |=>
      o_codec_oe_n == (~$past(i_codec_gpo_en) & $past(i_codec_func_oe_n)))
      else $error("codec pin enable mismatch");
   a_flash_lvl_mux: assert property (!i_srst |=>
      o_flash_lvl == (($past(i_flash_gpo_en) & $past(sh_f_ff)) |
      (~$past(i_flash_gpo_en) & $past(i_flash_func_lvl))))
      else $error("flash pin level mismatch");
   a_flash_oe_mux: assert property (!i_srst |=>
      o_flash_oe_n == (~$past(i_flash_gpo_en) & $past(i_flash_func_oe_n)))
      else $error("flash pin enable mismatch");
   a_codec_readback: assert property (i_bus.rd && i_bus.addr == gpodc_pkg::CODEC_DATA_OFS
      |=> o_rdata == {27'h0, $past(sh_c_ff)}) else $error("codec data readback mismatch");
   a_flash_readback: assert property (i_bus.rd && i_bus.addr == gpodc_pkg::FLASH_DATA_OFS
      |=> o_rdata == {27'h0, $past(sh_f_ff)}) else $error("flash data readback mismatch");
   a_rdata_quiet: assert property (!i_bus.rd |=> o_rdata == 32'h0)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (i_bus.rd && !map_ok |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_release: assert property ($fell(i_srst) |-> o_codec_oe_n == 5'h1f &&
      o_flash_oe_n == 5'h1f && o_codec_lvl == 5'h00 && o_flash_lvl == 5'h00)
      else $error("pins not idle after reset");
endmodule : gpodc_top_monitor

bind gpodc_top gpodc_top_monitor u_mon (.i_ref_clk, .i_srst, .i_bus, .o_rdata, .i_codec_gpo_en,
   .i_flash_gpo_en, .i_codec_func_lvl, .i_codec_func_oe_n, .i_flash_func_lvl, .i_flash_func_oe_n,
   .o_codec_lvl, .o_codec_oe_n, .o_flash_lvl, .o_flash_oe_n);

//--- verif/gpodc_top_test.sv
// testbench: register access and pin muxing of the codec/flash output block
`timescale 1ns/10ps
module gpodc_top_test;
   logic                      i_ref_clk;
   logic                      i_srst;
   gpodc_pkg::gpodc_bus_req_s bus;
   logic [31:0]               rdata;
   gpodc_pkg::gpodc_codec_s   c_en, c_fl, c_fo, c_lvl, c_oe;
   gpodc_pkg::gpodc_flash_s   f_en, f_fl, f_fo, f_lvl, f_oe;
   logic [9:0]                pins;
   int                        fail_count, n_compared;

   gpodc_top dut (.i_ref_clk, .i_srst, .i_bus(bus), .o_rdata(rdata), .i_codec_gpo_en(c_en),
      .i_flash_gpo_en(f_en), .i_codec_func_lvl(c_fl), .i_codec_func_oe_n(c_fo),
      .i_flash_func_lvl(f_fl), .i_flash_func_oe_n(f_fo), .o_codec_lvl(c_lvl),
      .o_codec_oe_n(c_oe), .o_flash_lvl(f_lvl), .o_flash_oe_n(f_oe));
   gpodc_pin_model u_pins (.i_ref_clk, .i_lvl({c_lvl, f_lvl}), .i_oe_n({c_oe, f_oe}), .o_pin(pins));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_ref_clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      @(posedge i_ref_clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge i_ref_clk);
      bus.rd <= 1'b0;
      @(negedge i_ref_clk);
      q = rdata;
   endtask : rd

   task automatic print_verdict();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset(input int n);
      logic [31:0] q;
      @(posedge i_ref_clk);
      i_srst <= 1'b1;
      repeat (n) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      rd(gpodc_pkg::CODEC_DATA_OFS, q);
      chk(q, 32'h0);
      rd(gpodc_pkg::FLASH_DATA_OFS, q);
      chk(q, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   // each pin enabled alone in turn, then none; function levels are the inverse of the data
   task automatic t_pins(input logic [4:0] dc, input logic [4:0] df);
      logic [31:0] q;
      logic [4:0]  en;
      wr(gpodc_pkg::CODEC_DATA_OFS, {27'h7ffffff, dc});
      wr(gpodc_pkg::FLASH_DATA_OFS, {27'h7ffffff, df});
      rd(gpodc_pkg::CODEC_DATA_OFS, q);
      chk(q, {27'h0, dc});
      rd(gpodc_pkg::FLASH_DATA_OFS, q);
      chk(q, {27'h0, df});
      for (int k = 0; k < 6; k++)
      begin
         en = 5'h01 << k;
         @(posedge i_ref_clk);
         c_en <= en;
         f_en <= en;
         c_fl <= ~dc;
         f_fl <= ~df;
         @(posedge i_ref_clk);
         @(negedge i_ref_clk);
         chk({27'h0, c_lvl}, {27'h0, (en & dc) | (~en & ~dc)});
         chk({27'h0, c_oe}, {27'h0, ~en & 5'h15});
         chk({27'h0, f_lvl}, {27'h0, (en & df) | (~en & ~df)});
         chk({27'h0, f_oe}, {27'h0, ~en & 5'h0a});
         chk({27'h0, pins[9:5] & en}, {27'h0, dc & en});
         chk({27'h0, pins[4:0] & en}, {27'h0, df & en});
      end
      $display("t_pins done");
   endtask : t_pins

   task automatic t_unmapped();
      logic [31:0] q;
      wr(12'h0ac, 32'hffffffff);
      rd(12'h0ac, q);
      chk(q, 32'h0);
      wr(gpodc_pkg::CODEC_LEVEL_OFS, 32'hffffffff);
      rd(gpodc_pkg::CODEC_LEVEL_OFS, q);
      chk(q, 32'h00001515);
      rd(gpodc_pkg::FLASH_LEVEL_OFS, q);
      chk(q, 32'h00000a0a);
      rd(gpodc_pkg::CODEC_DATA_OFS, q);
      chk(q, 32'h0000000a);
      $display("t_unmapped done");
   endtask : t_unmapped

   initial
   begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   initial
   begin
      #2000000;
      fail_count++;
      print_verdict();
   end

   initial
   begin
      i_srst = 1'b1;
      bus = '0;
      c_en = '0;
      f_en = '0;
      c_fl = '0;
      f_fl = '0;
      c_fo = 5'h15;
      f_fo = 5'h0a;
      fail_count = 0;
      n_compared = 0;
      t_reset(20);
      t_pins(5'h15, 5'h0a);
      t_pins(5'h0a, 5'h15);
      t_unmapped();
      t_reset(2);
      print_verdict();
   end
endmodule : gpodc_top_test

//--- verilog/gpodc_out_reg.sv
// module: one output data register with per-bit implemented mask
`timescale 1ns/10ps
module gpodc_out_reg #(
   parameter int unsigned                  W         = gpodc_pkg::DATA_W,
   parameter logic [gpodc_pkg::DATA_W-1:0] IMPL_MASK = gpodc_pkg::CODEC_IMPL_MASK,
   parameter logic [gpodc_pkg::DATA_W-1:0] RST_VAL   = gpodc_pkg::DATA_RST_VAL
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_srst,
   input  wire logic         i_wr_en,
   input  wire logic [W-1:0] i_wdata,
   output logic      [W-1:0] o_q
);

   // ***************************************************************
   // per-bit storage
   // ***************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++)
      begin : g_bit
         if (IMPL_MASK[gi])
         begin : g_impl
            logic q_ff;
            logic nxt_q;

            always_comb
            begin
               nxt_q = q_ff;
               if (i_wr_en)
               begin
                  nxt_q = i_wdata[gi];
               end
            end

            always_ff @(posedge i_ref_clk)
            begin
               if (i_srst)
               begin
                  q_ff <= RST_VAL[gi];
               end
               else
               begin
                  q_ff <= nxt_q;
               end
            end

            assign o_q[gi] = q_ff;
         end
         else
         begin : g_rsvd
            // reserved bit: no storage, writes dropped, reads zero
            assign o_q[gi] = 1'b0;
         end
      end
   endgenerate

endmodule : gpodc_out_reg

//--- verilog/gpodc_pkg.sv
// package: register map, field layout and pin bundles of the codec/flash output data block
package gpodc_pkg;

   // ***************************************************************
   // bus geometry
   // ***************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PIN_W  = 5;

   // ***************************************************************
   // register offsets (byte addresses)
   // ***************************************************************
   localparam logic [ADDR_W-1:0] CODEC_DATA_OFS  = 12'h0a4;
   localparam logic [ADDR_W-1:0] FLASH_DATA_OFS  = 12'h0a8;
   localparam logic [ADDR_W-1:0] CODEC_LEVEL_OFS = 12'h0f4;
   localparam logic [ADDR_W-1:0] FLASH_LEVEL_OFS = 12'h0f8;

   // ***************************************************************
   // implemented bits and reset values
   // ***************************************************************
   localparam logic [DATA_W-1:0] CODEC_IMPL_MASK = 32'h0000_001f;
   localparam logic [DATA_W-1:0] FLASH_IMPL_MASK = 32'h0000_001f;
   localparam logic [DATA_W-1:0] DATA_RST_VAL    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_ZERO       = 32'h0000_0000;

   // level readback layout: output enables above, levels below
   localparam int unsigned LEVEL_LSB = 0;
   localparam int unsigned OE_N_LSB  = 8;

   // ***************************************************************
   // bundles
   // ***************************************************************
   // bus request from the master
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } gpodc_bus_req_s;

   // codec link pins, bit 4 down to bit 0
   typedef struct packed {
      logic rst;
      logic bclk;
      logic sdo;
      logic sync;
      logic sdi;
   } gpodc_codec_s;

   // serial flash pins, bit 4 down to bit 0
   typedef struct packed {
      logic       sdi;
      logic       sclk;
      logic [1:0] cs;
      logic       sdo;
   } gpodc_flash_s;

endpackage : gpodc_pkg

//--- verilog/gpodc_top.sv
// module: codec link and serial flash general purpose output data registers and pin muxing
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module gpodc_top (
   input  wire logic                           i_ref_clk,
   input  wire logic                           i_srst,
   // register port
   input  wire gpodc_pkg::gpodc_bus_req_s      i_bus,
   output logic [gpodc_pkg::DATA_W-1:0]        o_rdata,
   // per-pin general purpose output enables
   input  wire gpodc_pkg::gpodc_codec_s        i_codec_gpo_en,
   input  wire gpodc_pkg::gpodc_flash_s        i_flash_gpo_en,
   // functional controller drive when a pin is not in general purpose use
   input  wire gpodc_pkg::gpodc_codec_s        i_codec_func_lvl,
   input  wire gpodc_pkg::gpodc_codec_s        i_codec_func_oe_n,
   input  wire gpodc_pkg::gpodc_flash_s        i_flash_func_lvl,
   input  wire gpodc_pkg::gpodc_flash_s        i_flash_func_oe_n,
   // pin drive
   output gpodc_pkg::gpodc_codec_s             o_codec_lvl,
   output gpodc_pkg::gpodc_codec_s             o_codec_oe_n,
   output gpodc_pkg::gpodc_flash_s             o_flash_lvl,
   output gpodc_pkg::gpodc_flash_s             o_flash_oe_n
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic                          codec_wr;
   logic                          flash_wr;
   logic [gpodc_pkg::DATA_W-1:0]  codec_data;
   logic [gpodc_pkg::DATA_W-1:0]  flash_data;
   gpodc_pkg::gpodc_codec_s       codec_bits;
   gpodc_pkg::gpodc_flash_s       flash_bits;

   gpodc_pkg::gpodc_codec_s       codec_lvl_ff;
   gpodc_pkg::gpodc_codec_s       nxt_codec_lvl;
   gpodc_pkg::gpodc_codec_s       codec_oe_n_ff;
   gpodc_pkg::gpodc_codec_s       nxt_codec_oe_n;
   gpodc_pkg::gpodc_flash_s       flash_lvl_ff;
   gpodc_pkg::gpodc_flash_s       nxt_flash_lvl;
   gpodc_pkg::gpodc_flash_s       flash_oe_n_ff;
   gpodc_pkg::gpodc_flash_s       nxt_flash_oe_n;

   logic [gpodc_pkg::DATA_W-1:0]  rdata_ff;
   logic [gpodc_pkg::DATA_W-1:0]  nxt_rdata;

   // ***************************************************************
   // write decode
   // ***************************************************************
   // only an exact offset match writes; other addresses are ignored
   always_comb
   begin
      codec_wr = i_bus.wr && (i_bus.addr == gpodc_pkg::CODEC_DATA_OFS);
      flash_wr = i_bus.wr && (i_bus.addr == gpodc_pkg::FLASH_DATA_OFS);
   end

   // ***************************************************************
   // output data registers
   // ***************************************************************
   // writes land whatever the pin configuration, so software may
   // preload a level before switching a pin to general purpose use
   gpodc_out_reg #(
      .W         (gpodc_pkg::DATA_W),
      .IMPL_MASK (gpodc_pkg::CODEC_IMPL_MASK),
      .RST_VAL   (gpodc_pkg::DATA_RST_VAL)
   ) u_codec_reg (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_wr_en   (codec_wr),
      .i_wdata   (i_bus.wdata),
      .o_q       (codec_data)
   );

   gpodc_out_reg #(
      .W         (gpodc_pkg::DATA_W),
      .IMPL_MASK (gpodc_pkg::FLASH_IMPL_MASK),
      .RST_VAL   (gpodc_pkg::DATA_RST_VAL)
   ) u_flash_reg (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_wr_en   (flash_wr),
      .i_wdata   (i_bus.wdata),
      .o_q       (flash_data)
   );

   // field view: packed struct order puts rst/sdi at bit 4, sdi/sdo at bit 0
   always_comb
   begin
      codec_bits = gpodc_pkg::gpodc_codec_s'(codec_data[gpodc_pkg::PIN_W-1:0]);
      flash_bits = gpodc_pkg::gpodc_flash_s'(flash_data[gpodc_pkg::PIN_W-1:0]);
   end

   // ***************************************************************
   // pin muxing
   // ***************************************************************
   // a pin in general purpose output use is driven from its data bit;
   // otherwise the functional controller owns level and enable
   genvar gp;
   generate
      for (gp = 0; gp < gpodc_pkg::PIN_W; gp++)
      begin : g_pin
         always_comb
         begin
            if (i_codec_gpo_en[gp])
            begin
               nxt_codec_lvl[gp]  = codec_bits[gp];
               nxt_codec_oe_n[gp] = 1'b0;
            end
            else
            begin
               nxt_codec_lvl[gp]  = i_codec_func_lvl[gp];
               nxt_codec_oe_n[gp] = i_codec_func_oe_n[gp];
            end
         end

         always_comb
         begin
            if (i_flash_gpo_en[gp])
            begin
               nxt_flash_lvl[gp]  = flash_bits[gp];
               nxt_flash_oe_n[gp] = 1'b0;
            end
            else
            begin
               nxt_flash_lvl[gp]  = i_flash_func_lvl[gp];
               nxt_flash_oe_n[gp] = i_flash_func_oe_n[gp];
            end
         end
      end
   endgenerate

   // pin drive registered so every pin sees a glitch-free level
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         codec_lvl_ff  <= '0;
         codec_oe_n_ff <= '1;
         flash_lvl_ff  <= '0;
         flash_oe_n_ff <= '1;
      end
      else
      begin
         codec_lvl_ff  <= nxt_codec_lvl;
         codec_oe_n_ff <= nxt_codec_oe_n;
         flash_lvl_ff  <= nxt_flash_lvl;
         flash_oe_n_ff <= nxt_flash_oe_n;
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   // data registers return stored bits with reserved bits zero; level
   // registers show what the pins are currently driven with
   always_comb
   begin
      nxt_rdata = gpodc_pkg::READ_ZERO;
      if (i_bus.rd)
      begin
         case (i_bus.addr)
            gpodc_pkg::CODEC_DATA_OFS:
            begin
               nxt_rdata = codec_data & gpodc_pkg::CODEC_IMPL_MASK;
            end
            gpodc_pkg::FLASH_DATA_OFS:
            begin
               nxt_rdata = flash_data & gpodc_pkg::FLASH_IMPL_MASK;
            end
            gpodc_pkg::CODEC_LEVEL_OFS:
            begin
               nxt_rdata[gpodc_pkg::LEVEL_LSB +: gpodc_pkg::PIN_W] = codec_lvl_ff;
               nxt_rdata[gpodc_pkg::OE_N_LSB  +: gpodc_pkg::PIN_W] = codec_oe_n_ff;
            end
            gpodc_pkg::FLASH_LEVEL_OFS:
            begin
               nxt_rdata[gpodc_pkg::LEVEL_LSB +: gpodc_pkg::PIN_W] = flash_lvl_ff;
               nxt_rdata[gpodc_pkg::OE_N_LSB  +: gpodc_pkg::PIN_W] = flash_oe_n_ff;
            end
            default:
            begin
               nxt_rdata = gpodc_pkg::READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         rdata_ff <= gpodc_pkg::READ_ZERO;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign o_rdata      = rdata_ff;
   assign o_codec_lvl  = codec_lvl_ff;
   assign o_codec_oe_n = codec_oe_n_ff;
   assign o_flash_lvl  = flash_lvl_ff;
   assign o_flash_oe_n = flash_oe_n_ff;

endmodule : gpodc_top
